// [shared/on_chip_data_ram_defs.svh]
// Constants for the on-chip data RAM access path.
// Assumes a byte-wide special-register port and a 16-bit external data address.
`ifndef ON_CHIP_DATA_RAM_DEFS_SVH
`define ON_CHIP_DATA_RAM_DEFS_SVH

// Page-select register location and reset value
`define ON_CHIP_DATA_RAM_PAGE_SFR_ADDR   8'hAA
`define ON_CHIP_DATA_RAM_PAGE_RESET      3'h0
`define ON_CHIP_DATA_RAM_PAGE_W          3

// Array geometry: 2048 bytes, low half user RAM, high half endpoint FIFO storage
`define ON_CHIP_DATA_RAM_BYTES           2048
`define ON_CHIP_DATA_RAM_AW              11
`define ON_CHIP_DATA_RAM_HALF_AW         10
`define ON_CHIP_DATA_RAM_HALF_BYTES      1024
`define ON_CHIP_DATA_RAM_FIFO_BIT        10

// Least system clock cycles from accept to done for a FIFO-region access
`define ON_CHIP_DATA_RAM_FIFO_MIN_CYCLES 3

`endif

// [shared/on_chip_data_ram_pkg.sv]
// Types shared by the system-side access logic and the FIFO-side RAM port.
// Assumes on_chip_data_ram_defs.svh is on the include path.
package on_chip_data_ram_pkg;
	`include "on_chip_data_ram_defs.svh"

	// Access sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FIFO = 2'b10
	} xfer_state_t;

	// System-clock side state
	typedef struct packed {
		xfer_state_t              fsm;        // Sequencer
		logic [`ON_CHIP_DATA_RAM_PAGE_W-1:0]  page;       // Page select bits
		logic [15:0]              addr;       // Full address of current access
		logic                     wr;         // Current access is a write
		logic [7:0]               wdata;      // Write byte
		logic [7:0]               rdata;      // Read byte to the CPU
		logic                     done;       // Completion pulse
		logic                     flash_wr;   // Flash write strobe
		logic [7:0]               sfr_rdata;  // Registered register read
		logic                     req_tgl;    // Request toggle to FIFO domain
		logic                     ack_meta;   // Ack synchroniser, first stage
		logic                     ack_sync;   // Ack synchroniser, second stage
		logic                     ack_seen;   // Last ack level consumed
	} sys_state_t;

	localparam sys_state_t SYS_RESET = '{fsm: ST_IDLE, default: '0};

	// FIFO-clock side state
	typedef struct packed {
		logic       rst_meta;  // Reset synchroniser, first stage
		logic       rst_sync;  // Reset synchroniser, second stage
		logic       req_meta;  // Request synchroniser, first stage
		logic       req_sync;  // Request synchroniser, second stage
		logic       req_seen;  // Last request level served
		logic       ack_tgl;   // Ack toggle back to system domain
		logic [7:0] rdata;     // Read byte, held until the next read
	} usb_state_t;
endpackage

// [core/on_chip_data_ram_fifo_port.sv]
// FIFO-region half of the data RAM, running on the USB clock.
// Assumes the request address, direction and data stay stable from the request
// toggle until the ack toggle returns; the system side guarantees that.
`timescale 1ns/100ps
`include "on_chip_data_ram_defs.svh"

module on_chip_data_ram_fifo_port (
	// USB clock and the system reset (synchronised here)
	input  wire logic                     i_usb_clock,
	input  wire logic                     i_rst,
	// Request from the system domain
	input  wire logic                     i_req_tgl,
	input  wire logic [`ON_CHIP_DATA_RAM_HALF_AW-1:0] i_addr,
	input  wire logic                     i_wr,
	input  wire logic [7:0]               i_wdata,
	// Answer to the system domain
	output logic                          o_ack_tgl,
	output logic [7:0]                    o_rdata
);
	import on_chip_data_ram_pkg::*;

	usb_state_t st;                                   // Registered state
	usb_state_t next_st;                              // Next state
	logic [7:0] fifo_mem [0:`ON_CHIP_DATA_RAM_HALF_BYTES-1];      // Upper 1k of the array
	logic       serve;                                // New request seen

	// Only the second stage is compared, never the first
	assign serve = (st.req_sync != st.req_seen) && !st.rst_sync;

	// Next-state logic; reset is applied after its own synchroniser
	always_comb begin
		next_st          = st;
		next_st.rst_meta = i_rst;
		next_st.rst_sync = st.rst_meta;
		next_st.req_meta = i_req_tgl;
		next_st.req_sync = st.req_meta;
		if (st.rst_sync) begin
			// Hold idle; adopt current request level so nothing is replayed
			next_st.req_seen = st.req_sync;
			next_st.ack_tgl  = st.req_sync;
			next_st.rdata    = 8'h00;
		end else if (serve) begin
			// Read and ack in one cycle on the USB clock
			next_st.req_seen = st.req_sync;
			next_st.ack_tgl  = ~st.ack_tgl;
			if (!i_wr) begin
				next_st.rdata = fifo_mem[i_addr];
			end
		end
	end

	// State register; the struct carries its own synchronous reset
	always_ff @(posedge i_usb_clock) begin
		st <= next_st;
	end

	// Storage write port, on the USB clock only
	always_ff @(posedge i_usb_clock) begin
		if (serve && i_wr) begin
			fifo_mem[i_addr] <= i_wdata;
		end
	end

	assign o_ack_tgl = st.ack_tgl;
	assign o_rdata   = st.rdata;

	default clocking @(posedge i_usb_clock); endclocking

	a_fifo_ack_toggle: assert property (serve |=> o_ack_tgl != $past(o_ack_tgl))
		else $error("FIFO request served without ack toggle");
	a_fifo_write_lands: assert property (serve && i_wr |=>
		fifo_mem[$past(i_addr)] == $past(i_wdata))
		else $error("FIFO region write not stored");
endmodule

// [core/on_chip_data_ram_access.sv]
// External data move decoder for the 2 kB on-chip data RAM.
// Assumes the CPU issues one-cycle requests only while o_xmove_ready is high,
// and that the USB clock runs whenever the FIFO region is addressed.
`timescale 1ns/100ps

// Offsets, field positions and timing counts
`include "on_chip_data_ram_defs.svh"

// Overview of operation
// - 2048-byte RAM in external data space
// - Low 1k user RAM, high 1k FIFO
// - Pointer or register-indirect external move access
// - Short address takes page select upper byte
// - RAM by default, flash when writes enabled
// - Top five address bits ignored, 2k aliasing
// - Unused FIFO space usable as plain RAM
// - FIFO half clocked by USB clock
// - FIFO accesses take more system cycles
module on_chip_data_ram_access (
	// Clock, reset, enable
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_clk_en,
	// USB clock for the FIFO half
	input  wire logic        i_usb_clock,
	// External move request from the CPU
	input  wire logic        i_xmove_req,
	input  wire logic        i_xmove_wr,
	input  wire logic        i_xmove_short,
	input  wire logic [15:0] i_xmove_addr,
	input  wire logic [7:0]  i_xmove_wdata,
	// External move answer
	output logic             o_xmove_ready,
	output logic             o_xmove_done,
	output logic [7:0]       o_xmove_rdata,
	// Special-register port
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic [7:0]       o_sfr_rdata,
	// Flash write path
	input  wire logic        i_flash_write_en,
	output logic             o_flash_wr,
	output logic [15:0]      o_flash_addr,
	output logic [7:0]       o_flash_wdata
);
	import on_chip_data_ram_pkg::*;

	sys_state_t st;                                   // Registered state
	sys_state_t next_st;                              // Next state
	logic [7:0] user_mem [0:`ON_CHIP_DATA_RAM_HALF_BYTES-1];      // Lower 1k, system clock

	logic [15:0]              cur_addr;      // Address of the incoming request
	logic                     accept;        // Request taken this cycle
	logic                     to_flash;      // Request goes to flash
	logic                     to_fifo;       // Request falls in the FIFO half
	logic [`ON_CHIP_DATA_RAM_AW-1:0]      ram_addr;      // Aliased array address
	logic [7:0]               user_rd;       // User RAM read byte
	logic                     fifo_ack;      // FIFO answer arrived
	logic                     fifo_ack_tgl;  // Ack toggle from FIFO domain
	logic [7:0]               fifo_rdata;    // Read byte from FIFO domain

	// Short form gets its upper byte from the page bits
	assign cur_addr = i_xmove_short ? {5'h00, st.page, i_xmove_addr[7:0]}
	                                : i_xmove_addr;
	// Top five bits dropped, so the array repeats every 2 kB
	assign ram_addr = cur_addr[`ON_CHIP_DATA_RAM_AW-1:0];
	assign accept   = (st.fsm == ST_IDLE) && i_xmove_req;
	// Flash is reached only by a write with flash writing enabled
	assign to_flash = i_xmove_wr && i_flash_write_en;
	assign to_fifo  = ram_addr[`ON_CHIP_DATA_RAM_FIFO_BIT];
	assign user_rd  = user_mem[ram_addr[`ON_CHIP_DATA_RAM_HALF_AW-1:0]];
	// Ack level is read only after the second synchroniser stage
	assign fifo_ack = st.ack_sync != st.ack_seen;

	// Next-state logic for the whole system-side path
	always_comb begin
		next_st          = st;
		next_st.done     = 1'b0;
		next_st.flash_wr = 1'b0;
		next_st.ack_meta = fifo_ack_tgl;
		next_st.ack_sync = st.ack_meta;

		// Page register write; upper bits are not stored
		if (i_sfr_wr && i_sfr_addr == `ON_CHIP_DATA_RAM_PAGE_SFR_ADDR) begin
			next_st.page = i_sfr_wdata[`ON_CHIP_DATA_RAM_PAGE_W-1:0];
		end
		// Register read; unmapped and unused bits read zero
		if (i_sfr_addr == `ON_CHIP_DATA_RAM_PAGE_SFR_ADDR) begin
			next_st.sfr_rdata = {5'h00, st.page};
		end else begin
			next_st.sfr_rdata = 8'h00;
		end

		case (st.fsm)
			ST_IDLE: begin
				if (i_xmove_req) begin
					next_st.addr  = cur_addr;
					next_st.wr    = i_xmove_wr;
					next_st.wdata = i_xmove_wdata;
					if (to_flash) begin
						// Flash write strobe, done in one cycle
						next_st.flash_wr = 1'b1;
						next_st.done     = 1'b1;
					end else if (to_fifo) begin
						// Hand over to the USB clock domain and stall
						next_st.req_tgl = ~st.req_tgl;
						next_st.fsm     = ST_FIFO;
					end else begin
						// User half answers on the next edge
						next_st.done = 1'b1;
						if (!i_xmove_wr) begin
							next_st.rdata = user_rd;
						end
					end
				end
			end
			ST_FIFO: begin
				// Wait for the ack to cross back; the CPU sees not-ready
				if (fifo_ack) begin
					next_st.ack_seen = st.ack_sync;
					next_st.done     = 1'b1;
					next_st.fsm      = ST_IDLE;
					if (!st.wr) begin
						// Stable: the FIFO side set it on the same edge that toggled ack
						next_st.rdata = fifo_rdata;
					end
				end
			end
			default: begin
				next_st.fsm = ST_IDLE;
			end
		endcase
	end

	// State register with synchronous reset and clock enable
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st <= SYS_RESET;
		end else if (i_clk_en) begin
			st <= next_st;
		end
	end

	// User RAM write port; frozen with the rest when the enable is low
	always_ff @(posedge i_clock) begin
		if (!i_rst && i_clk_en && accept && i_xmove_wr && !to_flash && !to_fifo) begin
			user_mem[ram_addr[`ON_CHIP_DATA_RAM_HALF_AW-1:0]] <= i_xmove_wdata;
		end
	end

	// FIFO half; its address and data come from held registers
	on_chip_data_ram_fifo_port u_fifo_port (
		.i_usb_clock (i_usb_clock),
		.i_rst       (i_rst),
		.i_req_tgl   (st.req_tgl),
		.i_addr      (st.addr[`ON_CHIP_DATA_RAM_HALF_AW-1:0]),
		.i_wr        (st.wr),
		.i_wdata     (st.wdata),
		.o_ack_tgl   (fifo_ack_tgl),
		.o_rdata     (fifo_rdata)
	);

	// Outputs; ready is combinational, data come from flip-flops
	assign o_xmove_ready = (st.fsm == ST_IDLE);
	assign o_xmove_done  = st.done;
	assign o_xmove_rdata = st.rdata;
	assign o_sfr_rdata   = st.sfr_rdata;
	assign o_flash_wr    = st.flash_wr;
	assign o_flash_addr  = st.addr;
	assign o_flash_wdata = st.wdata;

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);

	a_user_one_cycle: assert property (
		i_clk_en && accept && !to_flash && !to_fifo |=> o_xmove_done)
		else $error("User RAM access not done after one cycle");
	a_fifo_slower: assert property (
		i_clk_en && accept && !to_flash && to_fifo |=>
		!o_xmove_done && !o_xmove_ready ##1 !o_xmove_done)
		else $error("FIFO access completed too early");
	a_fifo_stall_hold: assert property (
		!o_xmove_ready && !fifo_ack |=> !o_xmove_ready && !o_xmove_done)
		else $error("FIFO stall released without ack");
	a_page_short_addr: assert property (
		i_clk_en && accept && i_xmove_short |=>
		st.addr == {5'h00, $past(st.page), $past(i_xmove_addr[7:0])})
		else $error("Short address not built from page bits");
	a_page_reg_write: assert property (
		i_clk_en && i_sfr_wr && i_sfr_addr == `ON_CHIP_DATA_RAM_PAGE_SFR_ADDR |=>
		st.page == $past(i_sfr_wdata[2:0]))
		else $error("Page register write lost");
	a_alias_select: assert property (
		i_clk_en && accept && !i_xmove_short |->
		ram_addr == i_xmove_addr[`ON_CHIP_DATA_RAM_AW-1:0] && to_fifo == i_xmove_addr[`ON_CHIP_DATA_RAM_FIFO_BIT])
		else $error("Region select uses aliased bits wrongly");
	a_user_read_data: assert property (
		i_clk_en && accept && !i_xmove_wr && !to_fifo |=>
		o_xmove_rdata == $past(user_rd))
		else $error("User RAM read data wrong");
	a_flash_route: assert property (
		i_clk_en && accept && to_flash |=> o_flash_wr && o_xmove_done)
		else $error("Enabled flash write not routed to flash");
	a_flash_default: assert property (
		o_flash_wr && $past(i_clk_en) |-> $past(i_flash_write_en) && $past(i_xmove_wr))
		else $error("Flash strobe without flash writing enabled");

	// Routing guards: flash is never the default target
	a_flash_off_ram: assert property (
		i_clk_en && accept && !i_flash_write_en |=> !o_flash_wr)
		else $error("Flash strobe while flash writing disabled");
	a_flash_read_ram: assert property (
		i_clk_en && accept && !i_xmove_wr |=> !o_flash_wr)
		else $error("Read routed to flash");
	// The FIFO side reads these without a copy of its own
	a_fifo_args_held: assert property (
		!o_xmove_ready |=> $stable(st.addr) && $stable(st.wr) && $stable(st.wdata))
		else $error("FIFO request changed while in flight");
	// Only three page bits exist; the rest read back as zero
	a_page_upper_zero: assert property (
		o_sfr_rdata[7:3] == 5'h00)
		else $error("Unused page register bits read nonzero");
endmodule

// [verification/on_chip_data_ram_cpu_model.sv]
// CPU-side model that issues single-byte external moves to the RAM decoder.
// Assumes the bench runs the clock and calls move one transfer at a time.
`timescale 1ns/100ps

module on_chip_data_ram_cpu_model (
	// Clock and answer from the decoder
	input  wire logic        i_clock,
	input  wire logic        i_ready,
	input  wire logic        i_done,
	input  wire logic [7:0]  i_rdata,
	// Move request
	output logic             o_req,
	output logic             o_wr,
	output logic             o_short,
	output logic [15:0]      o_addr,
	output logic [7:0]       o_wdata
);
	// Quiet request lines at time zero
	initial begin
		o_req   = 1'b0;
		o_wr    = 1'b0;
		o_short = 1'b0;
		o_addr  = 16'h0000;
		o_wdata = 8'h00;
	end

	// One move; n counts edges until done, q is the byte read
	// Moves reach the endpoint FIFO half as well as user RAM
	task automatic move(input logic wr, input logic sh, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q, output int n);
		n = 0;
		@(posedge i_clock);
		o_req   <= 1'b1;
		o_wr    <= wr;
		o_short <= sh;
		o_addr  <= a;
		o_wdata <= d;
		do begin
			@(posedge i_clock);
			n++;
			// Pulse is taken while ready is high
			if (n == 1 && i_ready === 1'b1) begin
				o_req <= 1'b0;
			end
		end while (i_done !== 1'b1 && n < 64);
		q = i_rdata;
		// Released address and data lines show the inverse, not the old value
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask
endmodule

// [verification/on_chip_data_ram_access_decoder_bench.sv]
// Self-checking bench for the external move decoder of the data RAM.
// Assumes the CPU model file is compiled first.
`timescale 1ns/100ps

module on_chip_data_ram_access_decoder_bench;
	import on_chip_data_ram_pkg::*;
	// One table row: move kind, address, byte written or expected
	typedef struct packed {logic wr; logic sh; logic [15:0] a; logic [7:0] d;} row_t;
	localparam row_t ROWS [11] = '{
		'{1, 0, 16'h0012, 8'h3C}, '{0, 0, 16'h0812, 8'h3C}, '{1, 0, 16'h0534, 8'hA7},
		'{0, 1, 16'h0034, 8'hA7}, '{0, 0, 16'hFD34, 8'hA7}, '{1, 0, 16'hF3FF, 8'h5A},
		'{1, 0, 16'h0400, 8'h11}, '{0, 0, 16'h03FF, 8'h5A}, '{0, 0, 16'h2C00, 8'h11},
		'{1, 1, 16'h00FF, 8'h6E}, '{0, 0, 16'h05FF, 8'h6E}};
	logic        clk, usb_clk, rst, clk_en, flash_en, sfr_wr;
	logic        req, wr, sh, ready, done, flash_wr;
	logic [15:0] addr, flash_addr, eff;
	logic [7:0]  wdata, rdata, sfr_addr, sfr_wdata, sfr_rdata, flash_wdata, q;
	int          err_count, cmp_count, cycles, n;

	on_chip_data_ram_access dut (.i_clock(clk), .i_rst(rst), .i_clk_en(clk_en), .i_usb_clock(usb_clk),
		.i_xmove_req(req), .i_xmove_wr(wr), .i_xmove_short(sh), .i_xmove_addr(addr),
		.i_xmove_wdata(wdata), .o_xmove_ready(ready), .o_xmove_done(done),
		.o_xmove_rdata(rdata), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr),
		.i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata), .i_flash_write_en(flash_en),
		.o_flash_wr(flash_wr), .o_flash_addr(flash_addr), .o_flash_wdata(flash_wdata));
	on_chip_data_ram_cpu_model cpu (.i_clock(clk), .i_ready(ready), .i_done(done), .i_rdata(rdata),
		.o_req(req), .o_wr(wr), .o_short(sh), .o_addr(addr), .o_wdata(wdata));

	// System clock, 5 ns
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// USB clock runs throughout, so FIFO moves always finish
	initial begin
		usb_clk = 1'b0;
		forever #3.5 usb_clk = ~usb_clk;
	end

	// Count and report one comparison
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (!ok) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// Register write, one edge wide
	task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge clk);
		sfr_wr    <= 1'b0;
	endtask
	// Register read, answer one edge after the address
	task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		sfr_addr <= a;
		repeat (2) @(posedge clk);
		chk(sfr_rdata === e, "register read");
	endtask
	// Reset for k edges; mid-run it is held long enough for the USB side too
	task automatic do_reset(input int k);
		rst <= 1'b1;
		repeat (k) @(posedge clk);
		rst <= 1'b0;
	endtask
	// Verdict and end of run
	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end

	// Main sequence
	initial begin
		rst = 1'b1; clk_en = 1'b1; flash_en = 1'b0; sfr_wr = 1'b0;
		sfr_addr = 8'h00; sfr_wdata = 8'h00; err_count = 0; cmp_count = 0; cycles = 0;
		do_reset(2);
		@(posedge clk);
		chk(ready === 1'b1 && done === 1'b0 && flash_wr === 1'b0 && rdata === 8'h00,
			"reset outputs");
		sfr_chk(8'hAA, 8'h00);
		sfr_put(8'hAA, 8'hFF);
		sfr_chk(8'hAA, 8'h07);
		sfr_put(8'hAA, 8'h05);
		sfr_put(8'hAB, 8'h02);
		sfr_chk(8'hAB, 8'h00);
		$display("test register done");
		// Table of moves: data, aliasing, page and latency per region
		foreach (ROWS[i]) begin
			cpu.move(ROWS[i].wr, ROWS[i].sh, ROWS[i].a, ROWS[i].d, q, n);
			eff = ROWS[i].sh ? {8'h05, ROWS[i].a[7:0]} : ROWS[i].a;
			chk(ROWS[i].wr || q === ROWS[i].d, "read data");
			chk(eff[10] ? (n >= 4 && n <= 16) : n == 2, "move latency");
		end
		$display("test table done");
		// Flash write only when enabled; reads still hit RAM
		cpu.move(1'b1, 1'b0, 16'h0234, 8'h42, q, n);
		flash_en <= 1'b1;
		cpu.move(1'b1, 1'b0, 16'h1234, 8'h99, q, n);
		chk(flash_wr === 1'b1 && flash_addr === 16'h1234, "flash address");
		chk(flash_wdata === 8'h99, "flash data");
		cpu.move(1'b0, 1'b0, 16'h0234, 8'h00, q, n);
		chk(q === 8'h42 && flash_wr === 1'b0, "read with flash on");
		flash_en <= 1'b0;
		$display("test flash done");
		// Frozen clock enable drops a register write
		clk_en <= 1'b0;
		sfr_put(8'hAA, 8'h01);
		clk_en <= 1'b1;
		sfr_chk(8'hAA, 8'h05);
		do_reset(6);
		chk(ready === 1'b1 && done === 1'b0 && rdata === 8'h00, "mid-run reset outputs");
		sfr_chk(8'hAA, 8'h00);
		$display("test reset done");
		summarize();
	end
endmodule
